// >>> design/dmba_map.svh
// address map constants for data memory bank addressing
`ifndef DMBA_MAP_SVH
`define DMBA_MAP_SVH
`define DMBA_BSEL_RESET 4'h0
`define DMBA_BSEL_HI_ZERO 4'h0
`define DMBA_ACC_LOW_LAST 8'h5F
`define DMBA_ACC_HIGH_FIRST 8'h60
`define DMBA_ADDR_RESET 12'h000
`define DMBA_BANK_BYTES 256
`define DMBA_SIGN_BIT 7
`define DMBA_ACC_LOW_BANK 4'h0
`define DMBA_ACC_HIGH_BANK 4'hF
`define DMBA_DATA_ZERO 8'h00
`define DMBA_ZERO_BIT 2
`define DMBA_NEG_BIT 4
`define DMBA_BANK_COUNT 16
`endif

// >>> design/dmba_pkg.sv
// types for data memory bank addressing
package dmba_pkg;
  typedef logic [3:0] dmba_bank_t;
  typedef logic [7:0] dmba_byte_t;
  typedef logic [11:0] dmba_addr_t;
  typedef enum logic [1:0] {
    DMBA_OP_NONE,
    DMBA_OP_DIRECT,
    DMBA_OP_MOVE,
    DMBA_OP_LOADBANK
  } dmba_op_t;
endpackage

// >>> design/dmba_mem_if.sv
// interface between address logic and the data memory
interface dmba_mem_if;
  import dmba_pkg::*;
  logic rd_en;
  logic wr_en;
  dmba_addr_t rd_addr;
  dmba_addr_t wr_addr;
  dmba_byte_t wr_data;
  dmba_byte_t rd_data;
  modport ctrl (output rd_en, output wr_en, output rd_addr, output wr_addr,
    output wr_data, input rd_data);
  modport mem (input rd_en, input wr_en, input rd_addr, input wr_addr,
    input wr_data, output rd_data);
endinterface

// >>> design/dmba_mem.sv
// banked static data memory with registered read data
`include "dmba_map.svh"
module dmba_mem #(
  parameter int BANKS_IMPL = `DMBA_BANK_COUNT
) (
  input wire logic core_clk, // core clock
  dmba_mem_if.mem bus // memory port
);
  import dmba_pkg::*;
  dmba_byte_t ram [0:(BANKS_IMPL*`DMBA_BANK_BYTES)-1];
  dmba_byte_t rd_ff;
  dmba_byte_t nxt_rd;
  logic rd_impl;
  logic wr_impl;
  always_comb begin
    rd_impl = (int'(bus.rd_addr[11:8]) < BANKS_IMPL);
    wr_impl = (int'(bus.wr_addr[11:8]) < BANKS_IMPL);
    nxt_rd = rd_ff;
    if (bus.rd_en) begin
      // unimplemented bank reads as zero
      nxt_rd = rd_impl ? ram[bus.rd_addr] : `DMBA_DATA_ZERO;
    end
  end
  always_ff @(posedge core_clk) begin
    rd_ff <= nxt_rd;
    if (bus.wr_en && wr_impl) begin
      ram[bus.wr_addr] <= bus.wr_data;
    end
  end
  assign bus.rd_data = rd_ff;
endmodule

// >>> design/dmba_top.sv
// direct data memory addressing with bank select and access window
`include "dmba_map.svh"
module dmba_top #(
  parameter int BANKS_IMPL = `DMBA_BANK_COUNT
) (
  input wire logic core_clk, // core clock
  input wire logic rst, // synchronous reset, active high
  input wire logic op_valid, // instruction request strobe
  input wire dmba_pkg::dmba_op_t op_kind, // instruction class
  input wire logic op_access_bit, // 0 selects access window
  input wire dmba_pkg::dmba_byte_t op_offset, // operand offset within bank
  input wire logic op_read, // direct: read operand
  input wire logic op_write, // direct: write result
  input wire dmba_pkg::dmba_byte_t op_wdata, // direct write data / bank literal
  input wire dmba_pkg::dmba_addr_t move_src, // move source address
  input wire dmba_pkg::dmba_addr_t move_dst, // move destination address
  output dmba_pkg::dmba_addr_t eff_addr, // registered effective address
  output dmba_pkg::dmba_byte_t rd_data, // registered read data
  output logic rd_valid, // read data valid pulse
  output logic zero_flag, // zero status of read value
  output logic neg_flag, // negative status of read value
  output dmba_pkg::dmba_byte_t bank_select_register // bank select readback
);
  import dmba_pkg::*;

  // ----------------------------------------
  // bank select register
  // ----------------------------------------
  dmba_bank_t bsel_ff;
  dmba_bank_t nxt_bsel;
  always_comb begin
    nxt_bsel = bsel_ff;
    if (op_valid && op_kind == DMBA_OP_LOADBANK) begin
      nxt_bsel = op_wdata[3:0];
    end
  end
  always_ff @(posedge core_clk) begin
    if (rst) begin
      bsel_ff <= `DMBA_BSEL_RESET;
    end else begin
      bsel_ff <= nxt_bsel;
    end
  end
  assign bank_select_register = {`DMBA_BSEL_HI_ZERO, bsel_ff};

  // ----------------------------------------
  // address formation
  // ----------------------------------------
  dmba_addr_t dir_addr;
  always_comb begin
    if (!op_access_bit) begin
      // window: low part of bank 0 then special function area of bank 15
      if (op_offset <= `DMBA_ACC_LOW_LAST) begin
        dir_addr = {`DMBA_ACC_LOW_BANK, op_offset};
      end else begin
        dir_addr = {`DMBA_ACC_HIGH_BANK, op_offset};
      end
    end else begin
      dir_addr = {bsel_ff, op_offset};
    end
  end

  // ----------------------------------------
  // memory request
  // ----------------------------------------
  dmba_mem_if mif ();
  logic is_dir;
  logic is_move;
  // move copies in two steps: read source, then write captured byte
  logic mv_pend_ff;
  logic nxt_mv_pend;
  dmba_addr_t mv_dst_ff;
  dmba_addr_t nxt_mv_dst;
  always_comb begin
    is_dir = op_valid && op_kind == DMBA_OP_DIRECT;
    is_move = op_valid && op_kind == DMBA_OP_MOVE && !mv_pend_ff;
    nxt_mv_pend = is_move;
    nxt_mv_dst = is_move ? move_dst : mv_dst_ff;
    mif.rd_en = (is_dir && op_read) || is_move;
    mif.rd_addr = is_move ? move_src : dir_addr;
    mif.wr_en = (is_dir && op_write) || mv_pend_ff;
    mif.wr_addr = mv_pend_ff ? mv_dst_ff : dir_addr;
    mif.wr_data = mv_pend_ff ? mif.rd_data : op_wdata;
  end
  always_ff @(posedge core_clk) begin
    if (rst) begin
      mv_pend_ff <= 1'b0;
      mv_dst_ff <= `DMBA_ADDR_RESET;
    end else begin
      mv_pend_ff <= nxt_mv_pend;
      mv_dst_ff <= nxt_mv_dst;
    end
  end

  dmba_mem #(
    .BANKS_IMPL(BANKS_IMPL)
  ) u_mem (
    .core_clk(core_clk),
    .bus(mif)
  );

  // ----------------------------------------
  // result and status
  // ----------------------------------------
  logic rv_ff;
  logic nxt_rv;
  dmba_addr_t ea_ff;
  dmba_addr_t nxt_ea;
  always_comb begin
    nxt_rv = mif.rd_en && !is_move;
    nxt_ea = ea_ff;
    if (is_dir) begin
      nxt_ea = dir_addr;
    end else if (is_move) begin
      nxt_ea = move_src;
    end
  end
  always_ff @(posedge core_clk) begin
    if (rst) begin
      rv_ff <= 1'b0;
      ea_ff <= `DMBA_ADDR_RESET;
    end else begin
      rv_ff <= nxt_rv;
      ea_ff <= nxt_ea;
    end
  end
  assign rd_valid = rv_ff;
  assign eff_addr = ea_ff;
  assign rd_data = mif.rd_data;
  // flags follow the value read, zero for an unimplemented bank
  assign zero_flag = (mif.rd_data == `DMBA_DATA_ZERO);
  assign neg_flag = mif.rd_data[`DMBA_SIGN_BIT];

  // ----------------------------------------
  // assertions: access window
  // ----------------------------------------
  // every address check looks one edge after the request, at the registered address
  property p_low_window;
    @(posedge core_clk) disable iff (rst)
    (is_dir && !op_access_bit && op_offset <= `DMBA_ACC_LOW_LAST) |=>
      (eff_addr[11:8] == `DMBA_ACC_LOW_BANK);
  endproperty
  a_low_window: assert property (p_low_window) else $error("low window bad");

  property p_high_window;
    @(posedge core_clk) disable iff (rst)
    (is_dir && !op_access_bit && op_offset > `DMBA_ACC_LOW_LAST) |=>
      (eff_addr[11:8] == `DMBA_ACC_HIGH_BANK);
  endproperty
  a_high_window: assert property (p_high_window) else $error("high window bad");

  // the byte after the last low-part byte must be the first high-part byte
  property p_window_join;
    @(posedge core_clk) disable iff (rst)
    (is_dir && !op_access_bit && op_offset == `DMBA_ACC_HIGH_FIRST) |=>
      (eff_addr == {`DMBA_ACC_HIGH_BANK, `DMBA_ACC_HIGH_FIRST});
  endproperty
  a_window_join: assert property (p_window_join) else $error("window not contiguous");

  // registers in the high part must be reachable with any bank selected
  property p_sfr_reach;
    @(posedge core_clk) disable iff (rst)
    (is_dir && !op_access_bit && op_offset > `DMBA_ACC_LOW_LAST &&
      bsel_ff != `DMBA_ACC_HIGH_BANK) |=> (eff_addr[11:8] == `DMBA_ACC_HIGH_BANK);
  endproperty
  a_sfr_reach: assert property (p_sfr_reach) else $error("high part needs banking");

  // the offset passes through untouched, only the upper nibble is chosen
  property p_window_offset;
    @(posedge core_clk) disable iff (rst)
    (is_dir && !op_access_bit) |=> (eff_addr[7:0] == $past(op_offset));
  endproperty
  a_window_offset: assert property (p_window_offset) else $error("window offset bad");

  // ----------------------------------------
  // assertions: bank select
  // ----------------------------------------
  // the bank is taken as it stood when the request was sampled
  property p_banked;
    @(posedge core_clk) disable iff (rst)
    (is_dir && op_access_bit) |=> (eff_addr == {$past(bsel_ff), $past(op_offset)});
  endproperty
  a_banked: assert property (p_banked) else $error("banked addr bad");

  property p_bsel_hi;
    @(posedge core_clk) disable iff (rst)
    (bank_select_register[7:4] == `DMBA_BSEL_HI_ZERO);
  endproperty
  a_bsel_hi: assert property (p_bsel_hi) else $error("bank select high set");

  // the literal's upper nibble must be dropped, not stored
  property p_loadbank;
    @(posedge core_clk) disable iff (rst)
    (op_valid && op_kind == DMBA_OP_LOADBANK) |=>
      (bank_select_register == {`DMBA_BSEL_HI_ZERO, $past(op_wdata[3:0])});
  endproperty
  a_loadbank: assert property (p_loadbank) else $error("load bank failed");

  // a stray bank change would silently redirect every banked access
  property p_bsel_hold;
    @(posedge core_clk) disable iff (rst)
    !(op_valid && op_kind == DMBA_OP_LOADBANK) |=> $stable(bank_select_register);
  endproperty
  a_bsel_hold: assert property (p_bsel_hold) else $error("bank changed unasked");

  // no disable here: this one watches the reset itself
  property p_reset_state;
    @(posedge core_clk)
    rst |=> (bank_select_register == {`DMBA_BSEL_HI_ZERO, `DMBA_BSEL_RESET}) &&
      (eff_addr == `DMBA_ADDR_RESET) && !rd_valid;
  endproperty
  a_reset_state: assert property (p_reset_state) else $error("reset state bad");

  // ----------------------------------------
  // assertions: memory-to-memory move
  // ----------------------------------------
  // moves are refused back to back, so only one write is ever pending
  property p_move_addr;
    @(posedge core_clk) disable iff (rst)
    is_move |=> (eff_addr == $past(move_src)) && mif.wr_en &&
      (mif.wr_addr == $past(move_dst));
  endproperty
  a_move_addr: assert property (p_move_addr) else $error("move addr bad");

  // a move is not a direct read, so it must not raise the result strobe
  property p_move_quiet;
    @(posedge core_clk) disable iff (rst)
    is_move |=> !rd_valid;
  endproperty
  a_move_quiet: assert property (p_move_quiet) else $error("move raised read valid");

  // the address only moves on a direct or move request
  property p_eff_hold;
    @(posedge core_clk) disable iff (rst)
    (!is_dir && !is_move) |=> $stable(eff_addr);
  endproperty
  a_eff_hold: assert property (p_eff_hold) else $error("address changed unasked");

  // ----------------------------------------
  // assertions: read result and status
  // ----------------------------------------
  // read data lives in the memory's output register, one edge after the request
  // an empty bank must still give the flags of a zero byte
  property p_zero_flag;
    @(posedge core_clk) disable iff (rst)
    (is_dir && op_read && int'(dir_addr[11:8]) >= BANKS_IMPL) |=>
      rd_valid && zero_flag && !neg_flag;
  endproperty
  a_zero_flag: assert property (p_zero_flag) else $error("zero flag bad");

  // a move from an empty bank reads zero as well
  property p_unimpl;
    @(posedge core_clk) disable iff (rst)
    (mif.rd_en && int'(mif.rd_addr[11:8]) >= BANKS_IMPL) |=>
      (rd_data == `DMBA_DATA_ZERO);
  endproperty
  a_unimpl: assert property (p_unimpl) else $error("unimpl bank nonzero");

  property p_rv;
    @(posedge core_clk) disable iff (rst)
    (is_dir && op_read) |=> rd_valid;
  endproperty
  a_rv: assert property (p_rv) else $error("read valid missing");

  // a strobe with no read behind it would hand the core a stale byte
  property p_rv_cause;
    @(posedge core_clk) disable iff (rst)
    rd_valid |-> $past(is_dir && op_read);
  endproperty
  a_rv_cause: assert property (p_rv_cause) else $error("read valid unasked");

  property p_write_quiet;
    @(posedge core_clk) disable iff (rst)
    (is_dir && op_write && !op_read) |=> !rd_valid;
  endproperty
  a_write_quiet: assert property (p_write_quiet) else $error("write raised read valid");

  // ----------------------------------------
  // coverage
  // ----------------------------------------
  // the main traffic kinds, one cover each
  c_window: cover property (@(posedge core_clk) is_dir && !op_access_bit);
  c_banked: cover property (@(posedge core_clk) is_dir && op_access_bit && op_write);
  c_move: cover property (@(posedge core_clk) is_move);
  c_load: cover property (@(posedge core_clk) op_valid && op_kind == DMBA_OP_LOADBANK);
  c_unimpl: cover property (@(posedge core_clk)
    is_dir && op_read && int'(dir_addr[11:8]) >= BANKS_IMPL);
endmodule

// >>> sim/dmba_core_model.sv
// core-side model that issues instructions to the addressing block
module dmba_core_model (
  input wire logic core_clk, // core clock
  output logic op_valid, // request strobe
  output dmba_pkg::dmba_op_t op_kind, // instruction class
  output logic op_access_bit, // 0 selects window
  output dmba_pkg::dmba_byte_t op_offset, // operand offset
  output logic op_read, // read enable
  output logic op_write, // write enable
  output dmba_pkg::dmba_byte_t op_wdata, // data or literal
  output dmba_pkg::dmba_addr_t move_src, // move source
  output dmba_pkg::dmba_addr_t move_dst // move destination
);
  timeunit 1ns;
  timeprecision 1ps;
  import dmba_pkg::*;
  initial begin
    {op_valid, op_access_bit, op_read, op_write} = 4'h0;
    op_kind = DMBA_OP_NONE;
    {op_offset, op_wdata} = 16'h0000;
    {move_src, move_dst} = 24'h000000;
  end
  // an idle cycle follows every request, so a move is never followed at once
  task automatic issue(input dmba_op_t k, input logic a, input dmba_byte_t off,
    input logic rd, input logic wr, input dmba_byte_t wd, input dmba_addr_t s, input dmba_addr_t d);
    @(posedge core_clk);
    op_valid <= 1'b1;
    op_kind <= k;
    op_access_bit <= a;
    op_offset <= off;
    op_read <= rd;
    op_write <= wr;
    op_wdata <= wd;
    move_src <= s;
    move_dst <= d;
    @(posedge core_clk);
    op_valid <= 1'b0;
    #1;
  endtask
endmodule

// >>> sim/tb_dmba_top.sv
// self-checking bench for direct data memory addressing
module tb_dmba_top;
  timeunit 1ns;
  timeprecision 1ps;
  import dmba_pkg::*;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic op_valid, op_access_bit, op_read, op_write, rd_valid, zero_flag, neg_flag;
  dmba_op_t op_kind;
  dmba_byte_t op_offset, op_wdata, rd_data, bsel, v, o, ev;
  dmba_addr_t move_src, move_dst, eff_addr;
  dmba_bank_t b;
  dmba_byte_t exp_q[$];
  int bad_count = 0;
  int checks = 0;
  int seed = 32961;
  initial begin
    forever #12.5 core_clk = ~core_clk;
  end
  dmba_core_model core (.core_clk(core_clk), .op_valid(op_valid), .op_kind(op_kind),
    .op_access_bit(op_access_bit), .op_offset(op_offset), .op_read(op_read),
    .op_write(op_write), .op_wdata(op_wdata), .move_src(move_src), .move_dst(move_dst));
  // bank 14 and 15 left unimplemented so the zero-read path is reachable
  dmba_top #(.BANKS_IMPL(14)) dut (.core_clk(core_clk), .rst(rst), .op_valid(op_valid),
    .op_kind(op_kind), .op_access_bit(op_access_bit), .op_offset(op_offset),
    .op_read(op_read), .op_write(op_write), .op_wdata(op_wdata), .move_src(move_src),
    .move_dst(move_dst), .eff_addr(eff_addr), .rd_data(rd_data), .rd_valid(rd_valid),
    .zero_flag(zero_flag), .neg_flag(neg_flag), .bank_select_register(bsel));
  task automatic conclude();
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic cmp_byte(input dmba_byte_t got, input dmba_byte_t exp, input string what);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic cmp_addr(input dmba_addr_t got, input dmba_addr_t exp);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %0t address got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic a, input dmba_byte_t off, input dmba_byte_t d);
    core.issue(DMBA_OP_DIRECT, a, off, 1'b0, 1'b1, d, 12'h000, 12'h000);
  endtask
  task automatic rd(input logic a, input dmba_byte_t off, input dmba_byte_t exp);
    exp_q.push_back(exp);
    core.issue(DMBA_OP_DIRECT, a, off, 1'b1, 1'b0, 8'h00, 12'h000, 12'h000);
  endtask
  task automatic lb(input dmba_byte_t lit);
    core.issue(DMBA_OP_LOADBANK, 1'b1, 8'h00, 1'b0, 1'b0, lit, 12'h000, 12'h000);
    cmp_byte(bsel, {4'h0, lit[3:0]}, "bank");
  endtask
  // --------------------------------
  // read result watcher
  // --------------------------------
  // sampled mid-cycle, where the strobe and data launched at the edge have settled
  always @(negedge core_clk) begin
    if (rd_valid === 1'b1) begin
      if (exp_q.size() == 0) begin
        bad_count++;
        $display("[FAIL] %0t read result with no request", $time);
      end else begin
        ev = exp_q.pop_front();
        cmp_byte(rd_data, ev, "read");
        cmp_byte({6'h00, zero_flag, neg_flag}, {6'h00, ev == 8'h00, ev[7]}, "flags");
      end
    end
  end
  initial begin
    #(25 * 3000);
    bad_count++;
    $display("[FAIL] %0t watchdog expired", $time);
    conclude();
  end
  initial begin
    repeat (4) @(posedge core_clk);
    rst <= 1'b0;
    #1;
    cmp_byte(bsel, 8'h00, "bank reset");
    for (int i = 0; i < 4; i++) begin
      v = $random(seed);
      lb(v);
    end
    $display("test bank literal done");
    for (int i = 0; i < 8; i++) begin
      b = 4'($unsigned($random(seed)) % 14);
      o = $random(seed);
      v = $random(seed);
      lb({4'hA, b});
      wr(1'b1, o, v);
      cmp_addr(eff_addr, {b, o});
      rd(1'b1, o, v);
      cmp_addr(eff_addr, {b, o});
    end
    $display("test banked access done");
    lb(8'h03);
    wr(1'b0, 8'h5F, 8'h3C);
    cmp_addr(eff_addr, 12'h05F);
    wr(1'b0, 8'h60, 8'h11);
    cmp_addr(eff_addr, 12'hF60);
    wr(1'b0, 8'hFF, 8'h22);
    cmp_addr(eff_addr, 12'hFFF);
    rd(1'b0, 8'h5F, 8'h3C);
    lb(8'h00);
    rd(1'b1, 8'h5F, 8'h3C);
    $display("test access window done");
    lb(8'h0E);
    wr(1'b1, 8'h21, 8'hA5);
    rd(1'b1, 8'h21, 8'h00);
    $display("test unimplemented bank done");
    lb(8'h02);
    wr(1'b1, 8'h40, 8'h96);
    lb(8'h05);
    core.issue(DMBA_OP_MOVE, 1'b1, 8'h00, 1'b0, 1'b0, 8'h00, 12'h240, 12'h7C1);
    cmp_addr(eff_addr, 12'h240);
    lb(8'h07);
    rd(1'b1, 8'hC1, 8'h96);
    repeat (2) @(posedge core_clk);
    cmp_byte(8'(exp_q.size()), 8'h00, "pending reads");
    $display("test move done");
    conclude();
  end
endmodule
